// ==== pcc_pkg.sv ====
// Package of constants for the PLL clock control register block
// Behaviour
// - Power-on reset loads value 0x2126
// - PLL enable gates output until lock
// - Bits 5:0 select system PLL frequency
// - Codes 0x1b..0x26 decode; 0x26 default; the code decodes all 64 codes 0x00..0x3f linearly
// - LCD field same table, half frequency
// - Mute clear: mute system clock unlocked
// - Mute set: mute only after resets or immediate update
// - Update clear: shadow until lock drops
// - Update set: write unlocks, inhibit system clock
package pcc_pkg;
	// Register offset of the only register
	localparam logic [7:0] PCC_CLK_CTRL_OFS = 8'h00;
	// Value after power-on reset
	localparam logic [15:0] PCC_CLK_CTRL_RST = 16'h2126;
	// Field positions
	localparam int PCC_SYS_FREQ_LSB = 0;
	localparam int PCC_UPD_MODE_BIT = 6;
	localparam int PCC_MUTE_BIT = 7;
	localparam int PCC_LCD_FREQ_LSB = 8;
	localparam int PCC_LCD_EN_BIT = 14;
	localparam int PCC_COMMS_EN_BIT = 15;
	localparam int PCC_FREQ_W = 6;
	// Frequency step per code, in Hz
	localparam logic [31:0] PCC_STEP_HZ = 32'd1843200;
	// Hold of the unlock request after an immediate update
	localparam logic [3:0] PCC_RELOCK_CYC = 4'h4;
	// Lock state machine states
	typedef enum logic [2:0] {
		PCC_ST_MUTED = 3'b001,
		PCC_ST_RUN = 3'b010,
		PCC_ST_RELOCK = 3'b100
	} pcc_state_e;
	// Code to frequency in Hz, linear in the code
	function automatic logic [31:0] pcc_code_hz(input logic [5:0] code);
		pcc_code_hz = 32'(code) * PCC_STEP_HZ;
	endfunction : pcc_code_hz
endpackage : pcc_pkg

// ==== pcc_sync.sv ====
// Three-stage synchroniser for a pin-level input
`timescale 1ns/1ps
module pcc_sync
	import pcc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_async,
	output logic o_level
);
	logic s1_q, s2_q, s3_q; // Stages
	logic lvl_q, lvl_d; // Filtered level
	// Accept change once stages two and three agree
	always_comb
	begin
		lvl_d = lvl_q;
		if (s2_q == s3_q)
		begin
			lvl_d = s3_q;
		end
	end
	// Register the stages
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
		end
		else if (i_ce)
		begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end
	assign o_level = lvl_q;
endmodule : pcc_sync

// ==== pcc_clock_control.sv ====
// PLL clock control register with lock gating and frequency update
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pcc_clock_control
	import pcc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_sys_lock_detect,
	input wire logic i_lcd_lock_detect,
	input wire logic i_comms_lock_detect,
	input wire logic i_external_reset,
	output logic [5:0] o_sys_freq_select,
	output logic [5:0] o_lcd_freq_select,
	output logic [31:0] o_sys_freq_hz,
	output logic [31:0] o_lcd_freq_hz,
	output logic o_sys_pll_unlock,
	output logic o_sys_clk_enable,
	output logic o_lcd_pll_output_enable,
	output logic o_comms_pll_output_enable
);
	// Synchronised lock inputs and reset pin
	logic sys_ld, lcd_ld, comms_ld, ext_rst;
	pcc_sync u_sys (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_async(i_sys_lock_detect), .o_level(sys_ld));
	pcc_sync u_lcd (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_async(i_lcd_lock_detect), .o_level(lcd_ld));
	pcc_sync u_com (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_async(i_comms_lock_detect), .o_level(comms_ld));
	pcc_sync u_ext (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_async(i_external_reset), .o_level(ext_rst));

	// Register state
	logic [15:0] ctrl_q, ctrl_d; // Software view
	logic [5:0] sys_act_q, sys_act_d; // Frequency applied to PLL
	logic [31:0] rdata_q, rdata_d; // Read data
	logic [3:0] relock_q, relock_d; // Unlock request counter
	logic sys_ld_q; // Previous lock level
	pcc_state_e st_q, st_d; // Mute state
	logic wr_hit; // Write to the register
	logic mute_sel, upd_sel; // Control bits

	assign wr_hit = i_wr && (i_addr == PCC_CLK_CTRL_OFS);
	assign mute_sel = ctrl_q[PCC_MUTE_BIT];
	assign upd_sel = ctrl_q[PCC_UPD_MODE_BIT];

	// Next register, shadow, read and mute state
	always_comb
	begin
		ctrl_d = ctrl_q;
		sys_act_d = sys_act_q;
		relock_d = relock_q;
		st_d = st_q;
		rdata_d = 32'h0;
		// Software write of the control word
		if (wr_hit)
		begin
			ctrl_d = i_wdata[15:0];
		end
		// Read path, upper bits zero
		if (i_rd)
		begin
			if (i_addr == PCC_CLK_CTRL_OFS)
			begin
				rdata_d = {16'h0, ctrl_q};
			end
			else
			begin
				rdata_d = 32'h0;
			end
		end
		// Immediate update unlocks the PLL
		if (wr_hit && i_wdata[PCC_UPD_MODE_BIT])
		begin
			sys_act_d = i_wdata[PCC_SYS_FREQ_LSB +: PCC_FREQ_W];
			relock_d = PCC_RELOCK_CYC;
			st_d = PCC_ST_RELOCK;
		end
		else if (relock_q != 4'h0)
		begin
			relock_d = relock_q - 4'h1;
		end
		// Shadow passes on lock falling
		if (sys_ld_q && !sys_ld && !upd_sel && !wr_hit)
		begin
			sys_act_d = ctrl_q[PCC_SYS_FREQ_LSB +: PCC_FREQ_W];
		end
		// Mute state machine
		case (st_q)
			PCC_ST_MUTED:
			begin
				if (sys_ld)
				begin
					st_d = PCC_ST_RUN;
				end
			end
			PCC_ST_RUN:
			begin
				if (!sys_ld && !mute_sel)
				begin
					st_d = PCC_ST_MUTED;
				end
			end
			PCC_ST_RELOCK:
			begin
				if (relock_q == 4'h0 && sys_ld)
				begin
					st_d = PCC_ST_RUN;
				end
			end
			default:
			begin
				st_d = PCC_ST_MUTED;
			end
		endcase
		// External reset mutes regardless of mode
		if (ext_rst)
		begin
			st_d = PCC_ST_MUTED;
		end
	end

	// Register all state
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ctrl_q <= PCC_CLK_CTRL_RST;
			sys_act_q <= PCC_CLK_CTRL_RST[5:0];
			relock_q <= 4'h0;
			st_q <= PCC_ST_MUTED;
			rdata_q <= 32'h0;
			sys_ld_q <= 1'b0;
		end
		else if (i_ce)
		begin
			ctrl_q <= ctrl_d;
			sys_act_q <= sys_act_d;
			relock_q <= relock_d;
			st_q <= st_d;
			rdata_q <= rdata_d;
			sys_ld_q <= sys_ld;
		end
	end

	// Outputs
	assign o_rdata = rdata_q;
	assign o_sys_freq_select = sys_act_q;
	assign o_lcd_freq_select = ctrl_q[PCC_LCD_FREQ_LSB +: PCC_FREQ_W];
	assign o_sys_freq_hz = pcc_code_hz(sys_act_q);
	assign o_lcd_freq_hz = pcc_code_hz(o_lcd_freq_select) >> 1;
	assign o_sys_pll_unlock = (relock_q != 4'h0);
	// Muted in MUTED and RELOCK, also when unlocked in mode clear
	assign o_sys_clk_enable = (st_q == PCC_ST_RUN)
		&& (sys_ld || mute_sel);
	assign o_lcd_pll_output_enable = ctrl_q[PCC_LCD_EN_BIT] && lcd_ld;
	assign o_comms_pll_output_enable = ctrl_q[PCC_COMMS_EN_BIT]
		&& comms_ld;

	// Reset value appears in the register
	reset_val_a: assert property (
		@(posedge i_clk)
		$past(i_reset) |-> ctrl_q == PCC_CLK_CTRL_RST)
		else $error("control word not at reset value");
	// Gated outputs follow enable bit and lock
	lcd_gate_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!ctrl_q[PCC_LCD_EN_BIT] |-> !o_lcd_pll_output_enable)
		else $error("lcd output enabled while bit clear");
	lcd_lock_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		o_lcd_pll_output_enable |-> lcd_ld)
		else $error("lcd output enabled without lock");
	comms_off_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!ctrl_q[PCC_COMMS_EN_BIT] |-> !o_comms_pll_output_enable)
		else $error("comms output enabled while bit clear");
	comms_gate_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		o_comms_pll_output_enable |-> comms_ld)
		else $error("comms output enabled without lock");
	// LCD frequency is half a system step per code
	lcd_half_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		o_lcd_freq_hz == 32'(o_lcd_freq_select) * (PCC_STEP_HZ >> 1))
		else $error("lcd frequency not half");
	// Mute clear: no clock while unlocked
	mute_unlock_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!mute_sel && !sys_ld |-> !o_sys_clk_enable)
		else $error("clock running while unlocked");
	// External reset always mutes
	ext_mute_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && ext_rst |=> !o_sys_clk_enable)
		else $error("clock running after external reset");
	// Mute set: lock loss alone keeps the clock running
	mute_keep_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && mute_sel && st_q == PCC_ST_RUN && !ext_rst
		&& !(wr_hit && i_wdata[PCC_UPD_MODE_BIT])
		|=> st_q == PCC_ST_RUN)
		else $error("clock muted by lock loss with mute set");
	// Deferred write waits in the shadow
	shadow_hold_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && wr_hit && !i_wdata[PCC_UPD_MODE_BIT] && !(sys_ld_q && !sys_ld)
		|=> $stable(sys_act_q))
		else $error("shadow passed without lock loss");
	// Lock loss hands the shadow to the PLL
	defer_pass_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && sys_ld_q && !sys_ld && !upd_sel && !wr_hit
		|=> o_sys_freq_select == $past(ctrl_q[PCC_SYS_FREQ_LSB +: PCC_FREQ_W]))
		else $error("shadow not passed on lock loss");
	// Immediate write unlocks and mutes at once
	imm_unlock_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && wr_hit && i_wdata[PCC_UPD_MODE_BIT]
		|=> o_sys_pll_unlock && !o_sys_clk_enable
		&& sys_act_q == $past(i_wdata[PCC_SYS_FREQ_LSB +: PCC_FREQ_W]))
		else $error("immediate update did not unlock");
	// Unlock request ends when the count runs out
	unlock_end_a: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_ce && relock_q == 4'h1 && !wr_hit |=> !o_sys_pll_unlock)
		else $error("unlock request held too long");
endmodule : pcc_clock_control

// ==== tb.sv ====
// Testbench for the PLL clock control register block
`timescale 1ns/1ps
module tb;
	import pcc_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [2:0] lock = 3'h0; // Comms, LCD, system lock pins
	logic ext_reset = 1'b0;
	logic ce = 1'b1; // Clock enable, low freezes the block
	logic [31:0] o_rdata, sys_hz, lcd_hz;
	logic [5:0] sys_sel, lcd_sel;
	logic unlock, clk_en, lcd_en, comms_en;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	pcc_clock_control pcc_clock_control_i (.i_clk(i_clk), .i_reset(i_reset),
		.i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_sys_lock_detect(lock[0]),
		.i_lcd_lock_detect(lock[1]), .i_comms_lock_detect(lock[2]),
		.i_external_reset(ext_reset), .o_sys_freq_select(sys_sel),
		.o_lcd_freq_select(lcd_sel), .o_sys_freq_hz(sys_hz),
		.o_lcd_freq_hz(lcd_hz), .o_sys_pll_unlock(unlock),
		.o_sys_clk_enable(clk_en), .o_lcd_pll_output_enable(lcd_en),
		.o_comms_pll_output_enable(comms_en));
	// Clock of 40 ns period
	always #20 i_clk = ~i_clk;
	// Hang guard
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			stop_test();
		end
	end
	// Wait whole cycles, then let the edge settle
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step
	// Compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	// One-cycle register read, data checked in the following cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd
	// Set lock pins and let the synchronisers follow
	task automatic setlock(input logic [2:0] l);
		@(posedge i_clk);
		lock <= l;
		step(8);
	endtask : setlock
	// Count summary and verdict
	task automatic stop_test();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// Main sequence
	initial
	begin
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		step(1);
		rd(8'h00, 32'h00002126);
		chk(32'(sys_sel), 32'h26);
		chk(sys_hz, 32'h042cc000);
		chk(32'(lcd_sel), 32'h21);
		chk(lcd_hz, 32'h01d01000);
		chk(32'(clk_en), 32'h0);
		$display("test reset done");
		setlock(3'b111);
		chk(32'(clk_en), 32'h1);
		chk(32'({lcd_en, comms_en}), 32'h0);
		wr(8'h00, 32'hffffc126);
		rd(8'h00, 32'h0000c126);
		rd(8'h04, 32'h0);
		step(1);
		chk(32'({lcd_en, comms_en}), 32'h3);
		setlock(3'b001);
		chk(32'({lcd_en, comms_en}), 32'h0);
		setlock(3'b111);
		chk(32'({lcd_en, comms_en}), 32'h3);
		$display("test enables done");
		setlock(3'b110);
		chk(32'(clk_en), 32'h0);
		setlock(3'b111);
		wr(8'h00, 32'h000000a5);
		step(1);
		chk(32'({lcd_en, comms_en}), 32'h0);
		setlock(3'b110);
		chk(32'(clk_en), 32'h1);
		chk(32'(sys_sel), 32'h25);
		chk(sys_hz, 32'h0410a000);
		setlock(3'b111);
		@(posedge i_clk);
		ext_reset <= 1'b1;
		step(5);
		chk(32'(clk_en), 32'h0);
		@(posedge i_clk);
		ext_reset <= 1'b0;
		step(8);
		chk(32'(clk_en), 32'h1);
		$display("test mute done");
		wr(8'h00, 32'h0000001b);
		step(2);
		chk(32'(sys_sel), 32'h25);
		setlock(3'b110);
		chk(32'(sys_sel), 32'h1b);
		chk(sys_hz, 32'h02f76000);
		setlock(3'b111);
		wr(8'h00, 32'h0000005c);
		step(2);
		chk(32'({unlock, clk_en}), 32'h2);
		chk(32'(sys_sel), 32'h1c);
		chk(sys_hz, 32'h03138000);
		step(10);
		chk(32'({unlock, clk_en}), 32'h1);
		$display("test update done");
		@(posedge i_clk);
		ce <= 1'b0;
		wr(8'h00, 32'h00000066);
		ce <= 1'b1;
		rd(8'h00, 32'h0000005c);
		chk(32'(sys_sel), 32'h1c);
		chk(32'({unlock, clk_en}), 32'h1);
		$display("test clock enable done");
		@(posedge i_clk);
		i_reset <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_reset <= 1'b0;
		step(1);
		chk(32'(clk_en), 32'h0);
		rd(8'h00, 32'h00002126);
		chk(32'(sys_sel), 32'h26);
		$display("test second reset done");
		stop_test();
	end
endmodule : tb
